/* File: pkg/smw_pkg.sv */
// Constants and types of the static memory timing and wait-state controller
package smw_pkg;
  localparam int CS_NUM = 4;
  // Register map: four registers per chip select, 16 bytes apart
  localparam logic [7:0] OFF_SETUP = 8'h00;
  localparam logic [7:0] OFF_PULSE = 8'h04;
  localparam logic [7:0] OFF_CYCLE = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0C;
  localparam logic [7:0] OFF_SCR = 8'h40;
  localparam logic [7:0] OFF_KEY1 = 8'h44;
  localparam logic [7:0] OFF_KEY2 = 8'h48;
  localparam logic [7:0] OFF_STAT = 8'h4C;
  localparam logic [3:0] K_SETUP = 4'h0;
  localparam logic [3:0] K_PULSE = 4'h1;
  localparam logic [3:0] K_CYCLE = 4'h2;
  localparam logic [3:0] K_MODE = 4'h3;
  localparam logic [3:0] K_SCR = 4'h4;
  localparam logic [3:0] K_KEY1 = 4'h5;
  localparam logic [3:0] K_KEY2 = 4'h6;
  localparam logic [3:0] K_STAT = 4'h7;
  localparam logic [3:0] K_NONE = 4'hF;
  localparam logic [31:0] SETUP_RST = 32'h0101_0101;
  localparam logic [31:0] PULSE_RST = 32'h0101_0101;
  localparam logic [31:0] CYCLE_RST = 32'h0003_0003;
  localparam logic [31:0] MODE_RST = 32'h0000_0003;
  localparam logic [31:0] SETUP_MASK = 32'h3F3F_3F3F;
  localparam logic [31:0] PULSE_MASK = 32'h7F7F_7F7F;
  localparam logic [31:0] CYCLE_MASK = 32'h01FF_01FF;
  localparam logic [31:0] MODE_MASK = 32'h0000_0003;
  localparam logic [31:0] SCR_MASK = 32'h0000_000F;
  // Field positions inside setup and pulse (write, cs write, read, cs read)
  localparam int WS_LSB = 0;
  localparam int CSW_LSB = 8;
  localparam int RS_LSB = 16;
  localparam int CSR_LSB = 24;
  localparam int WC_LSB = 0;
  localparam int RC_LSB = 16;
  localparam int MODE_RD_BIT = 0;
  localparam int MODE_WR_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RELOAD_BIT = 1;
  localparam int STAT_CS_LSB = 4;
  localparam int STAT_SLOW_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACC, ST_HOLDX} smw_state_t;
endpackage

/* File: verilog/smw_ctrl.sv */
// Static memory controller: timing registers, scrambling and automatic wait states
// ==========================================================
// Notes on behaviour
// [RULE1] Setup field decodes to 128 times bit 5 plus bits 4..0.
// [RULE2] Pulse field decodes to 256 times bit 6 plus bits 5..0.
// [RULE3] Cycle field decodes to 256 times bits 8..7 plus bits 6..0.
// [RULE4] Setup and pulse registers reset to 0x01010101.
// [RULE5] Cycle register resets to 0x00030003, three cycles with one hold.
// [RULE6] Write and read mode bits reset to 1, strobe controlled.
// [RULE7] Software keeps setup plus pulse within cycle; nothing is checked.
// [RULE8] Software never programs a zero pulse.
// [RULE9] Strobe-controlled write with zero hold keeps address and select afterwards.
// [RULE10] Scrambling on the fly, enabled per chip select.
// [RULE11] Two key registers shape scrambling; they are write only.
// [RULE12] One idle cycle with all strobes high between different selects.
// [RULE13] Early read wait only write then read on same select.
// [RULE14] Early read wait when write control hold and read control setup are zero.
// [RULE15] Select-controlled write: zero select hold and zero select read setup.
// [RULE16] Write strobe feedback still low: hold everything one more cycle.
// [RULE17] A mode register write inserts one reload wait before next access.
// [RULE18] Reload merges into select idle cycle; same select still waits.
// [RULE19] Only a mode register write triggers reload of parameters; the code also reloads on slow clock entry or exit.
// [RULE20] Software does not reprogram a select while it is being accessed.
// [RULE21] Slow clock entry or exit also causes a reload wait.
// [RULE22] Read followed by write always gets one extra wait cycle.
// [RULE23] Hold is cycle minus setup minus pulse, per strobe.
// [RULE24] Read data captured on edge raising the read-controlling strobe.
// [RULE25] Scrambling is a key-dependent invertible byte mapping.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module smw_ctrl
  import smw_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire logic mem_req_write,
  input wire logic [1:0] mem_req_cs,
  input wire logic [23:0] mem_req_addr,
  input wire logic [7:0] mem_req_wdata,
  output logic mem_rsp_valid,
  output logic [7:0] mem_rsp_rdata,
  input wire logic slow_clock_mode,
  output logic [23:0] addr_out,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] data_in,
  output logic [3:0] chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  input wire logic write_strobe_fb
);
  // ==========================================================
  // Decoding helpers
  function automatic logic [9:0] dec_setup(input logic [5:0] s);
    return {2'b00, s[5], 2'b00, s[4:0]}; // RULE1
  endfunction

  function automatic logic [9:0] dec_pulse(input logic [6:0] p);
    return {1'b0, p[6], 2'b00, p[5:0]}; // RULE2
  endfunction

  function automatic logic [9:0] dec_cycle(input logic [8:0] c);
    return {c[8:7], 1'b0, c[6:0]}; // RULE3
  endfunction

  function automatic logic in_win(input logic [9:0] c, input logic [9:0] s,
                                  input logic [9:0] p);
    return (c >= s) && (c < s + p);
  endfunction

  function automatic logic [3:0] reg_kind(input logic [7:0] a);
    logic [3:0] k;
    k = K_NONE;
    if (a < OFF_SCR) begin
      k = {2'b00, a[3:2]};
    end else begin
      case ({a[7:2], 2'b00})
        OFF_SCR: k = K_SCR;
        OFF_KEY1: k = K_KEY1;
        OFF_KEY2: k = K_KEY2;
        OFF_STAT: k = K_STAT;
        default: k = K_NONE;
      endcase
    end
    return k;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r & mask;
  endfunction

  // Rotation by key bits plus two xor layers; inverse undoes each step
  function automatic logic [7:0] scramble(input logic [7:0] d, input logic [7:0] ka,
                                          input logic [15:0] kb);
    logic [15:0] w;
    w = {d ^ ka, d ^ ka} << kb[2:0];
    return w[15:8] ^ kb[15:8];
  endfunction

  function automatic logic [7:0] unscramble(input logic [7:0] d, input logic [7:0] ka,
                                            input logic [15:0] kb);
    logic [15:0] w;
    w = {d ^ kb[15:8], d ^ kb[15:8]} >> kb[2:0];
    return w[7:0] ^ ka;
  endfunction

  // ==========================================================
  // Register bus slave
  logic aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic wr_do;
  logic [3:0] wr_kind, rd_kind;
  logic [1:0] wr_cs, rd_cs;
  logic [31:0] setup_reg [CS_NUM];
  logic [31:0] pulse_reg [CS_NUM];
  logic [31:0] cycle_reg [CS_NUM];
  logic [31:0] mode_reg [CS_NUM];
  logic [31:0] act_setup [CS_NUM];
  logic [31:0] act_pulse [CS_NUM];
  logic [31:0] act_cycle [CS_NUM];
  logic [31:0] act_mode [CS_NUM];
  logic [31:0] scr_en_reg, key_first_reg, key_second_reg;
  logic reload_pend_reg, slow_prev_reg, load_now;
  smw_state_t state_reg;
  logic [1:0] cur_cs_reg;

  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready = !w_have_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign wr_do = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_kind = reg_kind(aw_addr_reg);
  assign wr_cs = aw_addr_reg[5:4];
  assign rd_kind = reg_kind(s_axi_araddr);
  assign rd_cs = s_axi_araddr[5:4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && !aw_have_reg) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && !w_have_reg) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_do) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_kind == K_NONE || wr_kind == K_STAT) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      case (rd_kind)
        K_SETUP: rdata_reg <= setup_reg[rd_cs];
        K_PULSE: rdata_reg <= pulse_reg[rd_cs];
        K_CYCLE: rdata_reg <= cycle_reg[rd_cs];
        K_MODE: rdata_reg <= mode_reg[rd_cs];
        K_SCR: rdata_reg <= scr_en_reg;
        K_KEY1, K_KEY2: rdata_reg <= 32'h0000_0000; // RULE11
        K_STAT: begin
          rdata_reg <= 32'h0000_0000;
          rdata_reg[STAT_BUSY_BIT] <= (state_reg != ST_IDLE);
          rdata_reg[STAT_RELOAD_BIT] <= reload_pend_reg;
          rdata_reg[STAT_CS_LSB +: 2] <= cur_cs_reg;
          rdata_reg[STAT_SLOW_BIT] <= slow_prev_reg;
        end
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Programmed and active parameter sets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < CS_NUM; i++) begin
        setup_reg[i] <= SETUP_RST; // RULE4
        pulse_reg[i] <= PULSE_RST; // RULE4
        cycle_reg[i] <= CYCLE_RST; // RULE5
        mode_reg[i] <= MODE_RST; // RULE6
      end
    end else if (wr_do) begin
      for (int i = 0; i < CS_NUM; i++) begin
        if (wr_cs == 2'(i)) begin
          case (wr_kind)
            K_SETUP: setup_reg[i] <= merge(setup_reg[i], w_data_reg, w_strb_reg, SETUP_MASK);
            K_PULSE: pulse_reg[i] <= merge(pulse_reg[i], w_data_reg, w_strb_reg, PULSE_MASK);
            K_CYCLE: cycle_reg[i] <= merge(cycle_reg[i], w_data_reg, w_strb_reg, CYCLE_MASK);
            K_MODE: mode_reg[i] <= merge(mode_reg[i], w_data_reg, w_strb_reg, MODE_MASK);
            default: ;
          endcase
        end
      end
    end
  end

  // Timing edits stay invisible to the access engine until a reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < CS_NUM; i++) begin
        act_setup[i] <= SETUP_RST;
        act_pulse[i] <= PULSE_RST;
        act_cycle[i] <= CYCLE_RST;
        act_mode[i] <= MODE_RST;
      end
    end else if (load_now) begin
      for (int i = 0; i < CS_NUM; i++) begin
        act_setup[i] <= setup_reg[i];
        act_pulse[i] <= pulse_reg[i];
        act_cycle[i] <= cycle_reg[i];
        act_mode[i] <= mode_reg[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scr_en_reg <= 32'h0000_0000;
      key_first_reg <= 32'h0000_0000;
      key_second_reg <= 32'h0000_0000;
    end else if (wr_do) begin
      case (wr_kind)
        K_SCR: scr_en_reg <= merge(scr_en_reg, w_data_reg, w_strb_reg, SCR_MASK); // RULE10
        K_KEY1: key_first_reg <= merge(key_first_reg, w_data_reg, w_strb_reg, '1);
        K_KEY2: key_second_reg <= merge(key_second_reg, w_data_reg, w_strb_reg, '1);
        default: ;
      endcase
    end
  end

  // Set wins over the clear taken at access start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_pend_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
    end else begin
      slow_prev_reg <= slow_clock_mode;
      if ((wr_do && wr_kind == K_MODE) || (slow_clock_mode != slow_prev_reg)) begin
        reload_pend_reg <= 1'b1; // RULE19 RULE21
      end else if (load_now) begin
        reload_pend_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Access engine
  logic last_valid_reg, cur_wr_reg, hx_extra_reg, rsp_valid_reg;
  logic [1:0] wait_cnt_reg, n_wait;
  logic [9:0] cnt_reg;
  logic [23:0] req_addr_reg, addr_reg;
  logic [7:0] req_data_reg, wdata_reg, rsp_rdata_reg;
  logic [9:0] p_ws, p_csws, p_rs, p_csrs, p_wp, p_cswp, p_rp, p_csrp, p_wc, p_rc;
  logic [9:0] we_hold, csw_hold, cyc, rc_s, rc_p;
  logic wmode, rmode, accept, cs_chg, er_need, rw_need, go_acc, acc_last, rd_cap;
  logic [23:0] src_addr;
  logic [7:0] src_data, key_byte;

  assign p_ws = dec_setup(act_setup[cur_cs_reg][WS_LSB +: 6]);
  assign p_csws = dec_setup(act_setup[cur_cs_reg][CSW_LSB +: 6]);
  assign p_rs = dec_setup(act_setup[cur_cs_reg][RS_LSB +: 6]);
  assign p_csrs = dec_setup(act_setup[cur_cs_reg][CSR_LSB +: 6]);
  assign p_wp = dec_pulse(act_pulse[cur_cs_reg][WS_LSB +: 7]);
  assign p_cswp = dec_pulse(act_pulse[cur_cs_reg][CSW_LSB +: 7]);
  assign p_rp = dec_pulse(act_pulse[cur_cs_reg][RS_LSB +: 7]);
  assign p_csrp = dec_pulse(act_pulse[cur_cs_reg][CSR_LSB +: 7]);
  assign p_wc = dec_cycle(act_cycle[cur_cs_reg][WC_LSB +: 9]);
  assign p_rc = dec_cycle(act_cycle[cur_cs_reg][RC_LSB +: 9]);
  assign wmode = act_mode[cur_cs_reg][MODE_WR_BIT];
  assign rmode = act_mode[cur_cs_reg][MODE_RD_BIT];
  assign we_hold = p_wc - p_ws - p_wp; // RULE23
  assign csw_hold = p_wc - p_csws - p_cswp; // RULE23
  assign rc_s = rmode ? p_rs : p_csrs;
  assign rc_p = rmode ? p_rp : p_csrp;
  assign cyc = cur_wr_reg ? p_wc : p_rc;

  assign mem_req_ready = (state_reg == ST_IDLE);
  assign accept = mem_req_valid && mem_req_ready;
  assign cs_chg = last_valid_reg && (mem_req_cs != cur_cs_reg);
  // Same select only, so the parameters of the previous access still apply
  assign er_need = last_valid_reg && !cs_chg && cur_wr_reg && !mem_req_write && // RULE13
    ((((wmode ? we_hold : csw_hold) == 10'd0) && rc_s == 10'd0) || // RULE14
     (!wmode && csw_hold == 10'd0 && p_csrs == 10'd0)); // RULE15
  assign rw_need = last_valid_reg && !cur_wr_reg && mem_req_write;
  assign load_now = accept && reload_pend_reg; // RULE17
  // Select idle, reload and early read share one cycle; read-to-write adds one
  assign n_wait = {1'b0, cs_chg | reload_pend_reg | er_need} + {1'b0, rw_need}; // RULE18 RULE22
  assign go_acc = (accept && n_wait == 2'd0) || (state_reg == ST_WAIT && wait_cnt_reg == 2'd1);
  assign acc_last = (state_reg == ST_ACC) && ((cnt_reg + 10'd1) >= cyc);
  assign rd_cap = (state_reg == ST_ACC) && !cur_wr_reg && (cnt_reg == rc_s + rc_p - 10'd1);
  assign src_addr = (state_reg == ST_IDLE) ? mem_req_addr : req_addr_reg;
  assign src_data = (state_reg == ST_IDLE) ? mem_req_wdata : req_data_reg;
  assign key_byte = key_first_reg[8*src_addr[1:0] +: 8];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cur_cs_reg <= 2'd0;
      cur_wr_reg <= 1'b0;
      last_valid_reg <= 1'b0;
      wait_cnt_reg <= 2'd0;
      cnt_reg <= 10'd0;
      hx_extra_reg <= 1'b0;
      req_addr_reg <= 24'h00_0000;
      req_data_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            cur_cs_reg <= mem_req_cs;
            cur_wr_reg <= mem_req_write;
            last_valid_reg <= 1'b1;
            req_addr_reg <= mem_req_addr;
            req_data_reg <= mem_req_wdata;
            wait_cnt_reg <= n_wait;
            cnt_reg <= 10'd0;
            state_reg <= (n_wait == 2'd0) ? ST_ACC : ST_WAIT;
          end
        end
        ST_WAIT: begin
          wait_cnt_reg <= wait_cnt_reg - 2'd1;
          if (wait_cnt_reg == 2'd1) begin
            state_reg <= ST_ACC;
          end
        end
        ST_ACC: begin
          cnt_reg <= cnt_reg + 10'd1;
          if (acc_last) begin
            hx_extra_reg <= 1'b0;
            // Zero-hold strobe write keeps select and bus one cycle past the strobe
            if (cur_wr_reg && wmode && we_hold == 10'd0) begin
              state_reg <= ST_HOLDX; // RULE9
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_HOLDX: begin
          // One extra held cycle at most if the strobe has not risen yet
          if (!write_strobe_fb && !hx_extra_reg) begin
            hx_extra_reg <= 1'b1; // RULE16
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Bus lines change only when the access proper starts, not in wait cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_reg <= 24'h00_0000;
      wdata_reg <= 8'h00;
    end else if (go_acc) begin
      addr_reg <= src_addr;
      wdata_reg <= scr_en_reg[(state_reg == ST_IDLE) ? mem_req_cs : cur_cs_reg] ?
        scramble(src_data, key_byte, key_second_reg[15:0]) : src_data; // RULE10 RULE25
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_rdata_reg <= 8'h00;
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= acc_last;
      if (rd_cap) begin
        rsp_rdata_reg <= scr_en_reg[cur_cs_reg] ? // RULE24
          unscramble(data_in, key_first_reg[8*addr_reg[1:0] +: 8], key_second_reg[15:0]) :
          data_in; // RULE25
      end
    end
  end

  assign mem_rsp_valid = rsp_valid_reg;
  assign mem_rsp_rdata = rsp_rdata_reg;
  assign addr_out = addr_reg;
  assign data_out = wdata_reg;

  // ==========================================================
  // Strobes decode from registered state; all high in wait and idle cycles
  logic acc, rd_win, wr_win, cs_win;
  assign acc = (state_reg == ST_ACC);
  assign rd_win = acc && !cur_wr_reg && in_win(cnt_reg, p_rs, p_rp);
  assign wr_win = acc && cur_wr_reg && in_win(cnt_reg, p_ws, p_wp);
  assign cs_win = (acc && (cur_wr_reg ? in_win(cnt_reg, p_csws, p_cswp) :
                                        in_win(cnt_reg, p_csrs, p_csrp)))
                  || (state_reg == ST_HOLDX); // RULE9 RULE16
  assign read_strobe_n = !rd_win; // RULE12
  assign write_strobe_n = !wr_win; // RULE12
  assign chip_select_n = cs_win ? ~(4'b0001 << cur_cs_reg) : 4'b1111; // RULE12
  assign data_oe = (acc && cur_wr_reg && cnt_reg >= (wmode ? p_ws : p_csws))
                   || (state_reg == ST_HOLDX);
endmodule

/* File: verification/smw_chk.sv */
// Assertion checker for the static memory timing and wait-state controller
`timescale 1ns/10ps
module smw_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mem_req_valid,
  input wire logic mem_req_ready,
  input wire logic mem_rsp_valid,
  input wire logic [3:0] chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic data_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  idle_lines_a: assert property (mem_req_ready |->
    chip_select_n == 4'hF && read_strobe_n && write_strobe_n) else $error("lines active idle");
  one_select_a: assert property ($onehot0(~chip_select_n))
    else $error("two selects low");
  no_fight_a: assert property (!read_strobe_n |-> !data_oe && write_strobe_n)
    else $error("bus driven during read");
  take_busy_a: assert property (mem_req_valid && mem_req_ready |=> !mem_req_ready)
    else $error("ready after take");
  rsp_bound_a: assert property (mem_req_valid && mem_req_ready |-> ##[2:1000] mem_rsp_valid)
    else $error("access never ends");
  rsp_pulse_a: assert property (mem_rsp_valid |=> !mem_rsp_valid)
    else $error("response too long");
  rvalid_hold_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read answer dropped");
  bvalid_hold_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write answer dropped");
endmodule

bind smw_ctrl smw_chk chk_i (.*);

/* File: verification/smw_mem.sv */
// Behavioural byte-wide asynchronous memory on the far side of the controller
`timescale 1ns/10ps
module smw_mem (
  input wire logic aclk,
  input wire logic [3:0] chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [23:0] addr_out,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic slow_fb,
  output logic [7:0] data_in,
  output logic write_strobe_fb
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h5A;
  logic ws_d = 1'b1;
  always_ff @(posedge aclk) begin
    ws_d <= write_strobe_n;
    if (data_oe && chip_select_n != 4'hF)
      mem[addr_out[7:0]] <= data_out;
    if (!read_strobe_n)
      last <= mem[addr_out[7:0]];
  end
  // Released bus shows the inverse of the last value
  assign data_in = (!read_strobe_n && chip_select_n != 4'hF) ? mem[addr_out[7:0]] : ~last;
  // Heavy load: the pin rises one cycle late
  assign write_strobe_fb = slow_fb ? ws_d : write_strobe_n;
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the static memory timing and wait-state controller
`timescale 1ns/10ps
module tb_top;
  import smw_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, slow_clock_mode = 1'b0, slow_fb = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, mem_req_valid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, mem_req_write = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, mem_req_wdata = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, rd, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, chip_select_n;
  logic [1:0] mem_req_cs = 2'd0, s_axi_bresp, s_axi_rresp, resp;
  logic [23:0] mem_req_addr = 24'h00_0000, addr_out;
  logic [7:0] mem_rsp_rdata, data_out, data_in;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mem_req_ready, mem_rsp_valid, data_oe, read_strobe_n, write_strobe_n, write_strobe_fb;
  int fail_count = 0, checks = 0, lat, fall_k, low_n, cs_low;
  smw_ctrl uut (.*);
  smw_mem mem_i (.*);
  initial forever #20 aclk = ~aclk;
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 2000) begin
      fail_count++;
      end_sim();
    end
  endtask
  // ==========================================================
  // Bus cycles
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    b = 1'b0;
    for (n = 0; n < 2000 && !b; n++) begin
      @(negedge aclk);
      aw = s_axi_awready && s_axi_awvalid;
      w = s_axi_wready && s_axi_wvalid;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    bound(n);
    chk_val(32'(resp), 32'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, r;
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    r = 1'b0;
    for (n = 0; n < 2000 && !r; n++) begin
      @(negedge aclk);
      ar = s_axi_arready && s_axi_arvalid;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    bound(n);
    chk_val(32'(resp), 32'(er));
    chk_val(rd, ed);
  endtask
  // Latency counts cycles from the taking edge to the response pulse
  task automatic acc(input logic [1:0] cs, input logic wr, input logic [7:0] a,
      input logic [7:0] d, input int exp_lat);
    int n;
    logic seen, done;
    mem_req_cs <= cs;
    mem_req_write <= wr;
    mem_req_addr <= {16'h0000, a};
    mem_req_wdata <= d;
    mem_req_valid <= 1'b1;
    n = 0;
    do @(negedge aclk); while (!mem_req_ready && ++n < 2000);
    bound(n);
    @(posedge aclk);
    mem_req_valid <= 1'b0;
    lat = 0;
    fall_k = 0;
    low_n = 0;
    cs_low = 0;
    seen = 1'b0;
    done = 1'b0;
    for (n = 0; n < 2000 && !done; n++) begin
      @(negedge aclk);
      lat += !seen;
      if (!read_strobe_n && low_n == 0) fall_k = lat;
      low_n += !read_strobe_n;
      cs_low += !chip_select_n[cs];
      seen |= mem_rsp_valid;
      done = seen && mem_req_ready;
      rd = 32'(mem_rsp_rdata);
      @(posedge aclk);
    end
    bound(n);
    chk_val(32'(lat), 32'(exp_lat));
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] rv [4] = '{SETUP_RST, PULSE_RST, CYCLE_RST, MODE_RST};
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 4; k++)
        axi_rd(8'(16 * c + 4 * k), rv[k], RESP_OKAY);
    axi_wr(OFF_STAT, 32'h0000_0001, RESP_SLVERR);
    axi_rd(8'h50, 32'h0000_0000, RESP_SLVERR);
  endtask
  task automatic t_waits();
    acc(2'd0, 1'b1, 8'h10, 8'hA5, 4);
    acc(2'd0, 1'b0, 8'h10, 8'h00, 4);
    chk_val(rd, 32'h0000_00A5);
    acc(2'd0, 1'b1, 8'h11, 8'h5C, 5);
    acc(2'd1, 1'b0, 8'h11, 8'h00, 5);
    acc(2'd2, 1'b1, 8'h12, 8'h66, 6);
    axi_wr(8'h28, 32'h0004_0004, RESP_OKAY);
    acc(2'd2, 1'b1, 8'h12, 8'h67, 4);
    axi_wr(OFF_MODE, MODE_RST, RESP_OKAY);
    acc(2'd2, 1'b1, 8'h13, 8'h68, 6);
    axi_wr(OFF_MODE, MODE_RST, RESP_OKAY);
    acc(2'd1, 1'b1, 8'h21, 8'h3C, 5);
    slow_clock_mode <= 1'b1;
    @(posedge aclk);
    acc(2'd1, 1'b1, 8'h22, 8'h3D, 5);
    slow_clock_mode <= 1'b0;
    @(posedge aclk);
    acc(2'd1, 1'b1, 8'h22, 8'h3E, 5);
  endtask
  task automatic t_decode();
    axi_wr(8'h10, 32'h2121_0101, RESP_OKAY);
    axi_wr(8'h14, 32'h4141_0101, RESP_OKAY);
    axi_wr(8'h18, 32'h0103_0003, RESP_OKAY);
    axi_wr(8'h1C, MODE_RST, RESP_OKAY);
    acc(2'd1, 1'b0, 8'h21, 8'h00, 517);
    chk_val(32'(fall_k), 32'd131);
    chk_val(32'(low_n), 32'd257);
    chk_val(rd, 32'h0000_003C);
  endtask
  task automatic t_early();
    axi_wr(8'h30, 32'h0000_0101, RESP_OKAY);
    axi_wr(8'h38, 32'h0003_0002, RESP_OKAY);
    axi_wr(8'h3C, MODE_RST, RESP_OKAY);
    acc(2'd3, 1'b1, 8'h30, 8'h77, 5);
    chk_val(32'(cs_low), 32'd2);
    acc(2'd3, 1'b0, 8'h30, 8'h00, 5);
    chk_val(32'(fall_k), 32'd2);
    chk_val(rd, 32'h0000_0077);
    slow_fb <= 1'b1;
    acc(2'd3, 1'b1, 8'h31, 8'h88, 4);
    chk_val(32'(cs_low), 32'd3);
    slow_fb <= 1'b0;
  endtask
  task automatic t_scr();
    axi_wr(OFF_SCR, 32'h0000_0001, RESP_OKAY);
    axi_wr(OFF_KEY1, 32'h1234_5678, RESP_OKAY);
    axi_wr(OFF_KEY2, 32'h0000_A503, RESP_OKAY);
    axi_rd(OFF_KEY2, 32'h0000_0000, RESP_OKAY);
    acc(2'd0, 1'b1, 8'h42, 8'hC3, 5);
    chk_val(32'(mem_i.mem[8'h42]), 32'h0000_001A);
    acc(2'd0, 1'b0, 8'h42, 8'h00, 4);
    chk_val(rd, 32'h0000_00C3);
    acc(2'd1, 1'b1, 8'h43, 8'h5A, 6);
    chk_val(32'(mem_i.mem[8'h43]), 32'h0000_005A);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_waits();
    t_decode();
    t_early();
    t_scr();
    end_sim();
  end
endmodule
